// ### logic/fp_single_and_half_signed_load.sv
// load unit for single-precision and signed halfword loads, with AHB-Lite registers
`timescale 1ns/1ps
`include "ld_unit_consts.svh"
module fp_single_and_half_signed_load (
    input wire logic clock, // core clock
    input wire logic reset, // synchronous, active high
    input wire logic instrValid, // instruction offered
    output logic instrReady, // unit takes instruction
    input wire logic [31:0] instrWord, // instruction, bit 31 is msb
    input wire logic [31:0] baseVal, // contents of base gpr
    input wire logic [31:0] indexVal, // contents of index gpr
    output logic memReq, // access request
    output logic [31:0] memAddr, // effective address
    output logic memHalf, // 1 halfword, 0 word
    input wire logic memAck, // access answered
    input wire logic [31:0] memData, // read data, halfword in low bits
    input wire logic memAlignFault, // alignment fault
    input wire logic memStorageFault, // data storage fault
    output logic fprWe, // fp target write
    output logic [4:0] fprAddr, // fp target number
    output logic [63:0] fprData, // widened value
    output logic gprWe, // gp target write
    output logic [4:0] gprAddr, // gp target number
    output logic [31:0] gprData, // sign-extended halfword
    output logic baseWe, // base update write
    output logic [4:0] baseAddr, // base register number
    output logic [31:0] baseData, // effective address
    output logic faultValid, // fault pulse
    output logic faultAlign, // 1 alignment, 0 storage
    output logic illegalInstr, // unknown opcode pulse
    input wire logic hsel, // ahb select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    output logic hreadyout, // ahb slave ready
    output logic hresp, // ahb response
    output logic [31:0] hrdata, // ahb read data
    output logic irq // level interrupt
);
    ld_unit_pkg::state_type state;
    ld_unit_pkg::op_type op;
    ld_unit_pkg::op_type next_op;
    logic [4:0] tgtField;
    logic [4:0] baseField;
    logic [31:0] eaReg;
    logic [31:0] next_ea;
    logic [63:0] widened;
    logic accept;
    logic enable;
    logic [2:0] status;
    logic [2:0] mask;
    logic [2:0] events;
    logic [31:0] lastEa;
    logic [31:0] loadCount;
    logic wrPend;
    logic [11:0] wrAddr;
    logic goodAck;
    logic badAck;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] sext16(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction

    function automatic ld_unit_pkg::op_type decode(input logic [31:0] w);
        logic [5:0] opc;
        logic [9:0] xo;
        opc = w[`OPC_MSB:`OPC_LSB];
        xo = w[`XO_MSB:`XO_LSB];
        unique case (opc)
            `OPC_LFSU: return ld_unit_pkg::OP_LFSU;
            `OPC_LHA: return ld_unit_pkg::OP_LHA;
            `OPC_LHAU: return ld_unit_pkg::OP_LHAU;
            `OPC_EXT: begin
                if (xo == `XO_LFSUX) begin
                    return ld_unit_pkg::OP_LFSUX;
                end else if (xo == `XO_LFSX) begin
                    return ld_unit_pkg::OP_LFSX;
                end else begin
                    return ld_unit_pkg::OP_NONE;
                end
            end
            default: return ld_unit_pkg::OP_NONE;
        endcase
    endfunction

    function automatic logic isIndexed(input ld_unit_pkg::op_type o);
        return o == ld_unit_pkg::OP_LFSUX || o == ld_unit_pkg::OP_LFSX;
    endfunction

    function automatic logic isHalf(input ld_unit_pkg::op_type o);
        return o == ld_unit_pkg::OP_LHA || o == ld_unit_pkg::OP_LHAU;
    endfunction

    // base field zero means a zero base, not gpr 0
    function automatic logic [31:0] calcEa(input logic [31:0] w, input logic [31:0] b,
                                           input logic [31:0] x);
        logic [31:0] base;
        base = (w[`BASE_MSB:`BASE_LSB] == 5'h00) ? 32'h0000_0000 : b;
        if (isIndexed(decode(w))) begin
            return base + x;
        end
        return base + sext16(w[`DISP_MSB:0]);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // instruction intake and access sequencing
    assign next_op = decode(instrWord);
    assign next_ea = calcEa(instrWord, baseVal, indexVal);
    assign instrReady = enable && state == ld_unit_pkg::ST_IDLE;
    assign accept = instrValid && instrReady;
    assign memReq = state == ld_unit_pkg::ST_ACCESS;
    assign memAddr = eaReg;
    assign memHalf = isHalf(op);
    assign goodAck = memReq && memAck && !memAlignFault && !memStorageFault;
    assign badAck = memReq && memAck && (memAlignFault || memStorageFault);

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= ld_unit_pkg::ST_IDLE;
        end else begin
            unique case (state)
                ld_unit_pkg::ST_IDLE: begin
                    if (accept && next_op != ld_unit_pkg::OP_NONE) begin
                        state <= ld_unit_pkg::ST_ACCESS;
                    end
                end
                ld_unit_pkg::ST_ACCESS: begin
                    if (goodAck) begin
                        state <= ld_unit_pkg::ST_WRITE;
                    end else if (badAck) begin
                        state <= ld_unit_pkg::ST_IDLE;
                    end
                end
                ld_unit_pkg::ST_WRITE: begin
                    state <= ld_unit_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            op <= ld_unit_pkg::OP_NONE;
            tgtField <= 5'h00;
            baseField <= 5'h00;
            eaReg <= 32'h0000_0000;
        end else if (accept) begin
            op <= next_op;
            tgtField <= instrWord[`TGT_MSB:`TGT_LSB];
            baseField <= instrWord[`BASE_MSB:`BASE_LSB];
            eaReg <= next_ea;
        end
    end

    fp_single_widen u_widen (
        .singleVal(memData),
        .doubleVal(widened)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register writebacks; fp status, condition and exception registers untouched
    always_ff @(posedge clock) begin
        if (reset) begin
            fprWe <= 1'h0;
            gprWe <= 1'h0;
            baseWe <= 1'h0;
            fprAddr <= 5'h00;
            gprAddr <= 5'h00;
            baseAddr <= 5'h00;
            fprData <= 64'h0000_0000_0000_0000;
            gprData <= 32'h0000_0000;
            baseData <= 32'h0000_0000;
        end else begin
            fprWe <= goodAck && !isHalf(op);
            gprWe <= goodAck && isHalf(op);
            baseWe <= goodAck && baseField != 5'h00 && (op == ld_unit_pkg::OP_LFSU ||
                      op == ld_unit_pkg::OP_LFSUX ||
                      (op == ld_unit_pkg::OP_LHAU && baseField != tgtField));
            if (goodAck) begin
                fprAddr <= tgtField;
                gprAddr <= tgtField;
                baseAddr <= baseField;
                fprData <= widened;
                gprData <= sext16(memData[15:0]);
                baseData <= eaReg;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            faultValid <= 1'h0;
            faultAlign <= 1'h0;
            illegalInstr <= 1'h0;
        end else begin
            faultValid <= badAck;
            if (badAck) begin
                faultAlign <= memAlignFault;
            end
            illegalInstr <= accept && next_op == ld_unit_pkg::OP_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite register slave, zero wait states
    assign hreadyout = 1'h1;
    assign hresp = 1'h0;
    assign events = {illegalInstr, faultValid, fprWe | gprWe};
    assign irq = |(status & mask);

    always_ff @(posedge clock) begin
        if (reset) begin
            wrPend <= 1'h0;
            wrAddr <= 12'h000;
        end else if (hready) begin
            wrPend <= hsel && htrans[1] && hwrite;
            wrAddr <= haddr[11:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[11:0])
                `REG_CTRL: hrdata <= {31'h0, enable};
                `REG_STATUS: hrdata <= {29'h0, status};
                `REG_MASK: hrdata <= {29'h0, mask};
                `REG_LAST_EA: hrdata <= lastEa;
                `REG_COUNT: hrdata <= loadCount;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            enable <= `CTRL_RESET;
            mask <= 3'h0;
        end else if (wrPend && wrAddr == `REG_CTRL) begin
            enable <= hwdata[0];
        end else if (wrPend && wrAddr == `REG_MASK) begin
            mask <= hwdata[2:0];
        end
    end

    // write one clears, a new event in the same cycle wins
    always_ff @(posedge clock) begin
        if (reset) begin
            status <= 3'h0;
        end else if (wrPend && wrAddr == `REG_STATUS) begin
            status <= (status & ~hwdata[2:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            lastEa <= 32'h0000_0000;
            loadCount <= 32'h0000_0000;
        end else if (goodAck) begin
            lastEa <= eaReg;
            loadCount <= loadCount + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence sTake(logic [5:0] opc);
        accept && instrWord[`OPC_MSB:`OPC_LSB] == opc;
    endsequence

    sequence sGoodAccess;
        memReq && memAck && !memAlignFault && !memStorageFault;
    endsequence

    chk_lfsu_decode: assert property (
        sTake(`OPC_LFSU) |=> op == ld_unit_pkg::OP_LFSU && memReq && !memHalf
            && tgtField == $past(instrWord[`TGT_MSB:`TGT_LSB]))
        else $error("update single load not decoded");

    chk_lfsux_decode: assert property (
        sTake(`OPC_EXT) ##0 instrWord[`XO_MSB:`XO_LSB] == `XO_LFSUX
            |=> op == ld_unit_pkg::OP_LFSUX && memReq)
        else $error("indexed update single load not decoded");

    chk_lfsx_decode: assert property (
        sTake(`OPC_EXT) ##0 instrWord[`XO_MSB:`XO_LSB] == `XO_LFSX
            |=> op == ld_unit_pkg::OP_LFSX && memReq)
        else $error("indexed single load not decoded");

    chk_half_decode: assert property (
        sTake(`OPC_LHA) |=> op == ld_unit_pkg::OP_LHA && memReq && memHalf)
        else $error("halfword load not decoded");

    chk_halfu_decode: assert property (
        sTake(`OPC_LHAU) |=> op == ld_unit_pkg::OP_LHAU && memReq && memHalf)
        else $error("halfword update load not decoded");

    chk_fp_write: assert property (
        sGoodAccess ##0 !memHalf |=> fprWe && fprData == $past(widened) && !gprWe)
        else $error("single load did not write fp target");

    chk_disp_ea: assert property (
        accept && !isIndexed(next_op) && instrWord[`BASE_MSB:`BASE_LSB] == 5'h00
            |=> memAddr == sext16($past(instrWord[`DISP_MSB:0])))
        else $error("displacement address wrong");

    chk_index_ea: assert property (
        accept && isIndexed(next_op) |=> memAddr ==
            (($past(instrWord[`BASE_MSB:`BASE_LSB]) == 5'h00) ? $past(indexVal) :
            $past(baseVal) + $past(indexVal)))
        else $error("indexed address wrong");

    chk_lfsx_no_update: assert property (
        sGoodAccess ##0 op == ld_unit_pkg::OP_LFSX |=> !baseWe)
        else $error("indexed single load updated base");

    chk_half_sign: assert property (
        gprWe |-> gprData[31:16] == {16{gprData[15]}} && !fprWe)
        else $error("halfword not sign extended");

    chk_base_update: assert property (
        baseWe |-> baseAddr != 5'h00 && baseData == $past(eaReg)
            && !(gprWe && baseAddr == gprAddr))
        else $error("base update under wrong conditions");

    chk_fault_quiet: assert property (
        memReq && memAck && (memAlignFault || memStorageFault)
            |=> faultValid && !fprWe && !gprWe && !baseWe && (instrReady || !enable))
        else $error("faulting access wrote registers");

    chk_single_update: assert property (
        sGoodAccess ##0 (op == ld_unit_pkg::OP_LFSU || op == ld_unit_pkg::OP_LFSUX)
            ##0 baseField != 5'h00 |=> baseWe && baseAddr == $past(baseField))
        else $error("single update load did not write base");

    chk_half_same_base: assert property (
        sGoodAccess ##0 op == ld_unit_pkg::OP_LHAU ##0 baseField == tgtField |=> !baseWe)
        else $error("halfword update wrote base equal to target");
endmodule // fp_single_and_half_signed_load

// ### logic/ld_unit_consts.svh
// constants for the single-precision and signed halfword load unit
// How it works
// - opcode 49 is single load with update: fp target, base, 16-bit displacement
// - opcode 31 with extended code 567 is indexed single load with update
// - opcode 31 with extended code 535 is indexed single load, no writeback
// - opcode 42 is signed halfword load: gp target, base, displacement
// - opcode 43 is signed halfword load with update, same field layout
// - single loads read one word, widen to double, write fp target
// - displacement address is base plus sign-extended displacement, or displacement alone
// - indexed address is base plus index, or index alone when base field zero
// - single update loads write address to nonzero base when no fault
// - single loads leave fp status and condition field 0 untouched
// - halfword goes to low 16 target bits, its sign fills upper bits
// - plain halfword load leaves fixed-point exceptions and condition field untouched
// - halfword update writes base only if nonzero, unlike target, no fault
`ifndef LD_UNIT_CONSTS_SVH
`define LD_UNIT_CONSTS_SVH
`define OPC_MSB 31
`define OPC_LSB 26
`define TGT_MSB 25
`define TGT_LSB 21
`define BASE_MSB 20
`define BASE_LSB 16
`define IDX_MSB 15
`define IDX_LSB 11
`define DISP_MSB 15
`define XO_MSB 10
`define XO_LSB 1
`define OPC_LFSU 6'h31
`define OPC_EXT 6'h1f
`define OPC_LHA 6'h2a
`define OPC_LHAU 6'h2b
`define XO_LFSUX 10'h237
`define XO_LFSX 10'h217
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_MASK 12'h008
`define REG_LAST_EA 12'h00c
`define REG_COUNT 12'h010
`define CTRL_RESET 1'h0
`define EV_DONE 0
`define EV_FAULT 1
`define EV_ILLEGAL 2
`define SP_EXP_MAX 8'hff
`define DP_EXP_MAX 11'h7ff
`define DP_REBIAS 11'h380
`define DP_DENORM_BASE 11'h36a
`define SP_FRAC_W 5'h17
`endif

// ### logic/ld_unit_pkg.sv
// types shared by the load unit files
package ld_unit_pkg;
    typedef enum logic [2:0] {
        OP_NONE, OP_LFSU, OP_LFSUX, OP_LFSX, OP_LHA, OP_LHAU
    } op_type;
    typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_WRITE} state_type;
endpackage

// ### logic/fp_single_widen.sv
// single-precision to double-precision widening
`timescale 1ns/1ps
`include "ld_unit_consts.svh"
module fp_single_widen (
    input wire logic [31:0] singleVal, // single-precision word
    output logic [63:0] doubleVal // same value in double format
);
    logic [7:0] expIn;
    logic [22:0] frac;
    logic [4:0] lead;
    logic [4:0] shift;
    logic [22:0] normFrac;

    always_comb begin
        expIn = singleVal[30:23];
        frac = singleVal[22:0];
        lead = 5'h00;
        for (int i = 0; i < 23; i++) begin
            if (frac[i]) begin
                lead = 5'(i);
            end
        end
        shift = `SP_FRAC_W - lead;
        normFrac = 23'(frac << shift);
        if (expIn == 8'h00 && frac == 23'h00_0000) begin
            doubleVal = {singleVal[31], 63'h0};
        end else if (expIn == 8'h00) begin
            // denormal single is a normal double
            doubleVal = {singleVal[31], `DP_DENORM_BASE + {6'h00, lead}, normFrac, 29'h0};
        end else if (expIn == `SP_EXP_MAX) begin
            doubleVal = {singleVal[31], `DP_EXP_MAX, frac, 29'h0};
        end else begin
            doubleVal = {singleVal[31], {3'h0, expIn} + `DP_REBIAS, frac, 29'h0};
        end
    end
endmodule // fp_single_widen

// ### tb/mem_model.sv
// memory side model: answers each access request after a set delay
`timescale 1ns/1ps
module mem_model (
    input wire logic clock, // core clock
    input wire logic reset, // synchronous, active high
    input wire logic memReq, // access request from the unit
    input wire logic [1:0] delay, // extra cycles before the answer
    input wire logic [31:0] readWord, // word handed back on the answer
    input wire logic alignErr, // report an alignment fault
    input wire logic storageErr, // report a data storage fault
    output logic memAck, // one-cycle answer pulse
    output logic [31:0] memData, // read data, only valid with memAck
    output logic memAlignFault, // valid with memAck
    output logic memStorageFault // valid with memAck
);
    logic [1:0] waited;

    ////////////////////////////////////////////////////////////////////////
    // answer once per request, garbage outside the answer cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            memAck <= 1'b0;
            waited <= 2'h0;
            memData <= 32'h5a5a_a5a5;
            memAlignFault <= 1'b0;
            memStorageFault <= 1'b0;
        end else if (memReq && !memAck && waited == delay) begin
            memAck <= 1'b1;
            memData <= readWord;
            memAlignFault <= alignErr;
            memStorageFault <= storageErr;
        end else begin
            memAck <= 1'b0;
            waited <= (memReq && !memAck) ? waited + 2'h1 : 2'h0;
            memData <= ~memData;
            memAlignFault <= ~memAlignFault;
            memStorageFault <= ~memStorageFault;
        end
    end
endmodule // mem_model

// ### tb/testbench.sv
// self-checking bench for the single and signed halfword load unit
`timescale 1ns/1ps
`include "ld_unit_consts.svh"
module testbench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic instrValid = 1'b0;
    logic [31:0] instrWord = 32'h0000_0000;
    logic [31:0] baseVal = 32'h0000_0000;
    logic [31:0] indexVal = 32'h0000_0000;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] mDelay = 2'h0;
    logic [31:0] mWord = 32'h0000_0000;
    logic mAlign = 1'b0;
    logic mStore = 1'b0;
    logic [31:0] lastEa = 32'h0000_0000;
    logic instrReady, memReq, memHalf, memAck, memAlignFault, memStorageFault;
    logic fprWe, gprWe, baseWe, faultValid, faultAlign, illegalInstr;
    logic hready, hreadyout, hresp, irq;
    logic [4:0] fprAddr, gprAddr, baseAddr;
    logic [31:0] memAddr, memData, gprData, baseData, hrdata, rdv;
    logic [63:0] fprData;
    integer seed = 74829;
    int fails = 0;
    int compares = 0;
    int goods = 0;

    assign hready = hreadyout;
    always #4 clock = ~clock;

    fp_single_and_half_signed_load i_dut (.clock, .reset, .instrValid, .instrReady, .instrWord,
        .baseVal, .indexVal, .memReq, .memAddr, .memHalf, .memAck, .memData, .memAlignFault,
        .memStorageFault, .fprWe, .fprAddr, .fprData, .gprWe, .gprAddr, .gprData, .baseWe,
        .baseAddr, .baseData, .faultValid, .faultAlign, .illegalInstr, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq);
    mem_model i_mem (.clock, .reset, .memReq, .delay(mDelay), .readWord(mWord),
        .alignErr(mAlign), .storageErr(mStore), .memAck, .memData, .memAlignFault,
        .memStorageFault);

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_dword(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // single to double, denormals normalised
    function automatic logic [63:0] widen(input logic [31:0] s);
        logic [10:0] e;
        logic [23:0] m;
        e = 11'h381;
        m = {1'b0, s[22:0]};
        if (s[30:23] == 8'hff) return {s[31], 11'h7ff, s[22:0], 29'h0};
        if (s[30:23] != 8'h00) return {s[31], {3'h0, s[30:23]} + 11'h380, s[22:0], 29'h0};
        if (m == 24'h00_0000) return {s[31], 63'h0};
        while (!m[23]) begin
            m = m << 1;
            e = e - 11'h001;
        end
        return {s[31], e, m[22:0], 29'h0};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // single ahb-lite transfer, waits on hready in both phases
    task automatic ahb_xfer(input logic wr, input logic [31:0] a, wd, output logic [31:0] rd);
        int n;
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clock);
            n++;
        end while (hready !== 1'b1 && n < 100);
        rd = hrdata;
        cmp_bit(hresp, 1'b0);
        if (n >= 100) begin
            fails++;
            close_out;
        end
    endtask

    task automatic issue(input logic [31:0] w, bv, iv);
        int n;
        @(posedge clock);
        instrValid <= 1'b1;
        instrWord <= w;
        baseVal <= bv;
        indexVal <= iv;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (instrReady !== 1'b1 && n < 50);
        instrValid <= 1'b0;
        if (n >= 50) begin
            fails++;
            close_out;
        end
    endtask

    // k: 0 single upd, 1 single upd indexed, 2 single indexed, 3 half, 4 half upd
    task automatic run_load(input int k, input logic [4:0] t, b, input logic [15:0] lo,
            input logic [31:0] bv, iv, dat, input logic al, st);
        logic [31:0] w, ea;
        logic xf, flt, upd, seenP, seenG, seenB, seenF;
        int i, tail;
        xf = (k == 1 || k == 2);
        flt = al | st;
        w = xf ? {`OPC_EXT, t, b, lo[15:11], (k == 1) ? `XO_LFSUX : `XO_LFSX, lo[0]}
               : {(k == 0) ? `OPC_LFSU : (k == 3) ? `OPC_LHA : `OPC_LHAU, t, b, lo};
        ea = xf ? iv : {{16{lo[15]}}, lo};
        if (b != 5'h00) ea = ea + bv;
        upd = !flt && b != 5'h00 && (k < 2 || (k == 4 && b != t));
        {seenP, seenG, seenB, seenF, tail} = 0;
        mDelay <= 2'($random(seed));
        mWord <= dat;
        mAlign <= al;
        mStore <= st;
        issue(w, bv, iv);
        for (i = 0; i < 40 && tail < 3; i++) begin
            @(posedge clock);
            if (memReq === 1'b1) begin
                cmp_word(memAddr, ea);
                cmp_bit(memHalf, k > 2);
            end
            if (baseWe === 1'b1) begin
                seenB = 1'b1;
                cmp_word(baseData, ea);
                cmp_word({27'h0, baseAddr}, {27'h0, b});
            end
            if (fprWe === 1'b1) begin
                seenP = 1'b1;
                cmp_dword(fprData, widen(dat));
                cmp_word({27'h0, fprAddr}, {27'h0, t});
            end
            if (gprWe === 1'b1) begin
                seenG = 1'b1;
                cmp_word(gprData, {{16{dat[15]}}, dat[15:0]});
                cmp_word({27'h0, gprAddr}, {27'h0, t});
            end
            if (faultValid === 1'b1) begin
                seenF = 1'b1;
                cmp_bit(faultAlign, al);
            end
            if (seenP || seenG || seenF) tail++;
        end
        cmp_bit(seenF, flt);
        cmp_bit(seenP, !flt && k < 3);
        cmp_bit(seenG, !flt && k > 2);
        cmp_bit(seenB, upd);
        if (!flt) begin
            goods++;
            lastEa = ea;
        end
    endtask

    task automatic run_bad(input logic [31:0] w);
        logic seenI, seenR;
        seenI = 1'b0;
        seenR = 1'b0;
        issue(w, 32'h0000_0000, 32'h0000_0000);
        repeat (4) begin
            @(posedge clock);
            seenI |= (illegalInstr === 1'b1);
            seenR |= (memReq === 1'b1);
        end
        cmp_bit(seenI, 1'b1);
        cmp_bit(seenR, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        for (int a = 0; a < 6; a++) begin
            ahb_xfer(1'b0, 32'(a * 4), 32'h0000_0000, rdv);
            cmp_word(rdv, 32'h0000_0000);
        end
        cmp_bit(instrReady, 1'b0);
        ahb_xfer(1'b1, 32'h0000_0000, 32'h0000_0001, rdv);
        ahb_xfer(1'b0, 32'h0000_0000, 32'h0000_0000, rdv);
        cmp_word(rdv, 32'h0000_0001);
        run_load(0, 5'h05, 5'h00, 16'h8000, 32'h1000_0000, 0, 32'h3f80_0000, 0, 0);
        run_load(0, 5'h06, 5'h06, 16'h0004, 32'h0000_1000, 0, 32'h0000_0001, 0, 0);
        run_load(1, 5'h03, 5'h00, 16'h2000, 32'hdead_0000, 32'h0400, 32'hff80_0000, 0, 0);
        run_load(2, 5'h04, 5'h04, 16'h0801, 32'h0100, 32'h0010, 32'h7f80_0001, 0, 0);
        run_load(3, 5'h02, 5'h00, 16'hfffe, 32'h0, 0, 32'h1234_8001, 0, 0);
        run_load(4, 5'h07, 5'h07, 16'h0010, 32'h2000, 0, 32'h0000_7fff, 0, 0);
        run_load(4, 5'h07, 5'h09, 16'h0010, 32'h2000, 0, 32'h8000_0000, 1, 1);
        run_load(1, 5'h01, 5'h02, 16'h1800, 32'h0040, 32'h0008, 32'h8000_0000, 0, 1);
        run_bad({6'h30, 26'h000_0000});
        run_bad({`OPC_EXT, 15'h0, 10'h337, 1'h0});
        run_bad({`OPC_EXT, 15'h0, 10'h177, 1'h0});
        repeat (40) begin
            run_load($unsigned($random(seed)) % 5, 5'($random(seed)), 5'($random(seed)),
                16'($random(seed)), $random(seed), $random(seed), $random(seed),
                ($unsigned($random(seed)) % 8) == 0, ($unsigned($random(seed)) % 8) == 0);
        end
        ahb_xfer(1'b1, 32'h0000_000c, 32'h5555_5555, rdv);
        ahb_xfer(1'b0, 32'h0000_000c, 32'h0000_0000, rdv);
        cmp_word(rdv, lastEa);
        ahb_xfer(1'b0, 32'h0000_0010, 32'h0000_0000, rdv);
        cmp_word(rdv, 32'(goods));
        ahb_xfer(1'b0, 32'h0000_0004, 32'h0000_0000, rdv);
        cmp_word(rdv, 32'h0000_0007);
        cmp_bit(irq, 1'b0);
        ahb_xfer(1'b1, 32'h0000_0008, 32'h0000_0002, rdv);
        ahb_xfer(1'b0, 32'h0000_0008, 32'h0000_0000, rdv);
        cmp_word(rdv, 32'h0000_0002);
        cmp_bit(irq, 1'b1);
        ahb_xfer(1'b1, 32'h0000_0004, 32'h0000_0002, rdv);
        ahb_xfer(1'b0, 32'h0000_0004, 32'h0000_0000, rdv);
        cmp_word(rdv, 32'h0000_0005);
        cmp_bit(irq, 1'b0);
        ahb_xfer(1'b1, 32'h0000_0000, 32'h0000_0000, rdv);
        ahb_xfer(1'b0, 32'h0000_0000, 32'h0000_0000, rdv);
        cmp_bit(instrReady, 1'b0);
        close_out;
    end

    // hang guard
    initial begin
        #700000;
        fails++;
        close_out;
    end
endmodule // testbench
